// ===== hdl/spindle_regs_pkg.sv
// holds the register map, field positions, reset values and timing counts for the spindle/voice-coil register bank
// assumes a single 10 MHz clock shared with the host that drives the serial register port
// Functional notes
// - fine count low byte writable at 6Eh
// - status bit0 low during overtemperature shutdown
// - status bit1 low on overtemperature warning
// - status bit2 low without sequential back-EMF
// - status bit3 high on spindle fault
// - status bit4 low while back-EMF masked
// - status bit5 low when period exceeds 16ms
// - bits6/7 low during align and go
// - loop bit0 selects chop slew rate
// - loop bit1 selects charge pump current
// - loop bit3 routes sense to pin
// - bits5,4,3 select sense voltage limit
// - bits6/7 force charge pump low/high
// - control bit2 connects 2V reference
// - control bit4 doubles start-up times
// - control bit5 enables voice-coil section
// - serial transfers LSB first, direction then address
package spindle_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (seven-bit serial address field)
  localparam logic [6:0] ADDR_FINE_LOW   = 7'h6E;
  localparam logic [6:0] ADDR_STATUS     = 7'h7E;
  localparam logic [6:0] ADDR_LOOP_CTRL  = 7'h8E;
  localparam logic [6:0] ADDR_SYS_CTRL   = 7'h9E;

  // reset values: power-on reset clears every internal register
  localparam logic [7:0] RST_FINE_LOW    = 8'h00;
  localparam logic [7:0] RST_LOOP_CTRL   = 8'h00;
  localparam logic [7:0] RST_SYS_CTRL    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // status field positions
  localparam int ST_OVERTEMP_SHUTDOWN_N = 0;
  localparam int ST_OVERTEMP_WARNING_N  = 1;
  localparam int ST_NO_BACK_EMF_N       = 2;
  localparam int ST_SPINDLE_FAULT       = 3;
  localparam int ST_BEMF_MASKED_N       = 4;
  localparam int ST_SPEED_LOCK_ERROR_N  = 5;
  localparam int ST_START_PHASE_ONE_N   = 6;
  localparam int ST_START_PHASE_TWO_N   = 7;

  // spindle loop register field positions
  localparam int LP_CHOP_SLEW      = 0;
  localparam int LP_PUMP_CURRENT   = 1;
  localparam int LP_UNUSED         = 2;
  localparam int LP_SENSE_TO_PIN   = 3;
  localparam int LP_LIMIT_HI       = 4;
  localparam int LP_LIMIT_LO       = 5;
  localparam int LP_PUMP_FORCE_LO  = 6;
  localparam int LP_PUMP_FORCE_HI  = 7;

  // system control field positions
  localparam int SC_PARK_VOLT_A    = 0;
  localparam int SC_PARK_VOLT_B    = 1;
  localparam int SC_REF_CONNECT    = 2;
  localparam int SC_PARK_TIME_A    = 3;
  localparam int SC_STARTUP_X2     = 4;
  localparam int SC_VCM_ENABLE     = 5;
  localparam int SC_PARK_TIME_B    = 6;
  localparam int SC_HEAD_PARK      = 7;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_FREQ_HZ       = 10_000_000;
  localparam int SPEED_LOCK_MS     = 16;
  // longest spindle period before the lock error: 160000 cycles, a top parameter default
  localparam int SPEED_LOCK_CYCLES = CLK_FREQ_HZ / 1000 * SPEED_LOCK_MS;
  localparam int PERIOD_CNT_W      = 18;

  // serial frame: one direction bit, seven address bits, eight data bits
  localparam int FRAME_BITS        = 16;

endpackage

// ===== hdl/serial_port_shifter.sv
// holds the serial shift engine: LSB-first frames of direction, address and data
// assumes the frame select and serial clock arrive as pins, synchronised here with three flops each
`timescale 1ns/10ps
module serial_port_shifter
  import spindle_regs_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // serial pins
  input  wire logic       ser_sel_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_din,
  output logic            ser_dout,
  output logic            ser_dout_oe,
  // register side
  output logic            wr_stb,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            rd_req,
  output logic [6:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  typedef struct packed {
    logic [2:0]  sel_sync;
    logic [2:0]  clk_sync;
    logic [2:0]  din_sync;
    logic        sel_act;
    logic        clk_lvl;
    logic [4:0]  bit_cnt;
    logic        is_read;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [7:0]  rsh;
    logic        dout;
    logic        oe;
    logic        wr;
    logic        rd;
  } shift_st_t;

  shift_st_t st_ff;
  shift_st_t nxt_st;

  //////////////////////////////////////////////////////////////////////////////
  // a select or clock pin change counts only once stages two and three agree; data is taken from stage three as it stands
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.wr       = 1'b0;
    nxt_st.rd       = 1'b0;
    nxt_st.sel_sync = {st_ff.sel_sync[1:0], ser_sel_n};
    nxt_st.clk_sync = {st_ff.clk_sync[1:0], ser_clk};
    nxt_st.din_sync = {st_ff.din_sync[1:0], ser_din};
    if (st_ff.sel_sync[2] == st_ff.sel_sync[1]) begin
      nxt_st.sel_act = ~st_ff.sel_sync[2];
    end
    if (st_ff.clk_sync[2] == st_ff.clk_sync[1]) begin
      nxt_st.clk_lvl = st_ff.clk_sync[2];
    end
    if (!nxt_st.sel_act) begin
      // frame ended or idle: drop back and release the data pin
      nxt_st.bit_cnt = 5'h00;
      nxt_st.oe      = 1'b0;
    end else if (st_ff.sel_act && nxt_st.clk_lvl && !st_ff.clk_lvl
                 && st_ff.bit_cnt < 5'(FRAME_BITS)) begin
      // rising serial edge: sample one bit, least significant first
      if (st_ff.bit_cnt == 5'h00) begin
        nxt_st.is_read = st_ff.din_sync[2];
      end else if (st_ff.bit_cnt < 5'h08) begin
        nxt_st.addr = {st_ff.din_sync[2], st_ff.addr[6:1]};
      end else begin
        nxt_st.data = {st_ff.din_sync[2], st_ff.data[7:1]};
      end
      nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
      if (st_ff.bit_cnt == 5'h07 && nxt_st.is_read) begin
        nxt_st.rd = 1'b1;
      end
      if (st_ff.bit_cnt == 5'(FRAME_BITS - 1) && !st_ff.is_read) begin
        nxt_st.wr = 1'b1;
      end
    end else if (st_ff.sel_act && !nxt_st.clk_lvl && st_ff.clk_lvl
                 && st_ff.is_read && st_ff.bit_cnt >= 5'h08
                 && st_ff.bit_cnt < 5'(FRAME_BITS + 1)) begin
      // falling serial edge in a read: present next data bit, LSB first
      nxt_st.oe   = 1'b1;
      nxt_st.dout = st_ff.rsh[0];
      nxt_st.rsh  = {1'b0, st_ff.rsh[7:1]};
    end
    // read data is captured the cycle after the address completes
    if (st_ff.rd) begin
      nxt_st.rsh = rd_data;
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.sel_sync <= 3'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ser_dout    = st_ff.dout;
  assign ser_dout_oe = st_ff.oe;
  assign wr_stb      = st_ff.wr;
  assign wr_addr     = st_ff.addr;
  assign wr_data     = st_ff.data;
  assign rd_req      = st_ff.rd;
  assign rd_addr     = st_ff.addr;

endmodule // serial_port_shifter

// ===== hdl/spindle_vcm_status_ctrl_regs.sv
// holds the fine-count, status, spindle-loop and system-control registers behind the serial port
// assumes analog status levels arrive unsynchronised and that the host shares mclk
`timescale 1ns/10ps
module spindle_vcm_status_ctrl_regs
  import spindle_regs_pkg::*;
#(
  parameter int SPEED_LOCK_LIMIT = SPEED_LOCK_CYCLES
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // serial register port
  input  wire logic       ser_sel_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_din,
  output logic            ser_dout,
  output logic            ser_dout_oe,
  // analog monitor levels
  input  wire logic       overtemp_shutdown_in,
  input  wire logic       overtemp_warning_in,
  input  wire logic       fast_decel_in,
  input  wire logic       zero_cross_fast_in,
  input  wire logic       bemf_mask_in,
  input  wire logic       start_align_in,
  input  wire logic       start_go_in,
  input  wire logic       zero_cross_evt_in,
  input  wire logic       period_tick_in,
  // fine count output
  output logic [7:0]      fine_count_low,
  // spindle loop controls
  output logic            spindle_chop_slew_sel,
  output logic            pump_current_sel,
  output logic            sense_to_pin_sel,
  output logic [2:0]      sense_limit_code,
  output logic            pump_force_low,
  output logic            pump_force_high,
  output logic            spindle_drive_tristate,
  // system controls
  output logic [1:0]      park_volt_code,
  output logic            ref_connect,
  output logic [1:0]      park_time_code,
  output logic            startup_time_x2,
  output logic            voice_coil_enable,
  output logic            head_park_command
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // serial engine
  logic       wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_req;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  serial_port_shifter u_shift (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ser_sel_n   (ser_sel_n),
    .ser_clk     (ser_clk),
    .ser_din     (ser_din),
    .ser_dout    (ser_dout),
    .ser_dout_oe (ser_dout_oe),
    .wr_stb      (wr_stb),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data),
    .rd_req      (rd_req),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state of the bank
  localparam int NUM_MON = 9;

  typedef struct packed {
    logic [NUM_MON-1:0]    mon_s1;
    logic [NUM_MON-1:0]    mon_s2;
    logic [NUM_MON-1:0]    mon_s3;
    logic [NUM_MON-1:0]    mon;
    logic [7:0]            fine_low;
    logic [7:0]            loop_ctrl;
    logic [7:0]            sys_ctrl;
    logic [PERIOD_CNT_W-1:0] period_cnt;
    logic                  lock_err;
  } bank_st_t;

  bank_st_t st_ff;
  bank_st_t nxt_st;

  logic [NUM_MON-1:0] mon_raw;
  logic [NUM_MON-1:0] mon_agree;

  assign mon_raw = {period_tick_in, zero_cross_evt_in, start_go_in, start_align_in, bemf_mask_in,
                    zero_cross_fast_in, fast_decel_in, overtemp_warning_in, overtemp_shutdown_in};

  // per-input filter: stage two and three must agree before the level moves
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MON; gi++) begin : g_mon
      assign mon_agree[gi] = (st_ff.mon_s2[gi] == st_ff.mon_s3[gi]);
    end
  endgenerate

  logic tick_rise;
  logic [7:0] status_word;

  // edges are taken from the filtered copy, never from a first stage;
  // built from the filter flops so the edge does not loop back through nxt_st
  assign tick_rise = mon_agree[8] & st_ff.mon_s3[8] & ~st_ff.mon[8];

  // status image, active-low flags per field except the active-high spindle fault in bit3
  always_comb begin
    status_word                         = 8'hFF;
    status_word[ST_OVERTEMP_SHUTDOWN_N] = ~st_ff.mon[0];
    status_word[ST_OVERTEMP_WARNING_N]  = ~st_ff.mon[1];
    status_word[ST_NO_BACK_EMF_N]       = ~st_ff.lock_err | st_ff.mon[7] ? 1'b1 : 1'b0;
    status_word[ST_SPINDLE_FAULT]       = st_ff.mon[2] | st_ff.mon[3];
    status_word[ST_BEMF_MASKED_N]       = ~st_ff.mon[4];
    status_word[ST_SPEED_LOCK_ERROR_N]  = ~st_ff.lock_err;
    status_word[ST_START_PHASE_ONE_N]   = ~st_ff.mon[5];
    status_word[ST_START_PHASE_TWO_N]   = ~st_ff.mon[6];
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.mon_s1     = mon_raw;
    nxt_st.mon_s2     = st_ff.mon_s1;
    nxt_st.mon_s3     = st_ff.mon_s2;
    for (int i = 0; i < NUM_MON; i++) begin
      if (mon_agree[i]) begin
        nxt_st.mon[i] = st_ff.mon_s3[i];
      end
    end
    // period watchdog: a tick restarts the count, reaching SPEED_LOCK_LIMIT flags the lock error and holds the count
    if (tick_rise) begin
      nxt_st.period_cnt = '0;
      nxt_st.lock_err   = 1'b0;
    end else if (st_ff.period_cnt >= PERIOD_CNT_W'(SPEED_LOCK_LIMIT)) begin
      nxt_st.lock_err   = 1'b1;
    end else begin
      nxt_st.period_cnt = st_ff.period_cnt + PERIOD_CNT_W'(1);
    end
    // register writes; read-only and unmapped addresses ignore writes
    if (wr_stb) begin
      case (wr_addr)
        ADDR_FINE_LOW:  nxt_st.fine_low  = wr_data;
        ADDR_LOOP_CTRL: nxt_st.loop_ctrl = wr_data;
        ADDR_SYS_CTRL:  nxt_st.sys_ctrl  = wr_data;
        default: ;
      endcase
    end
  end

  // the single state register; power-on reset clears every register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.fine_low  <= RST_FINE_LOW;
      st_ff.loop_ctrl <= RST_LOOP_CTRL;
      st_ff.sys_ctrl  <= RST_SYS_CTRL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // only the status word reads back; write-only and unmapped addresses read as zero.
  // combinational so the shifter latches it on the edge that ends the request pulse
  assign rd_data = (rd_req && rd_addr == ADDR_STATUS) ? status_word : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // control outputs straight from the registers
  assign fine_count_low         = st_ff.fine_low;
  assign spindle_chop_slew_sel  = st_ff.loop_ctrl[LP_CHOP_SLEW];
  assign pump_current_sel       = st_ff.loop_ctrl[LP_PUMP_CURRENT];
  assign sense_to_pin_sel       = st_ff.loop_ctrl[LP_SENSE_TO_PIN];
  // code: {sense_to_pin, hi, lo}; 0..3 normal 0.45-0.75V, 4..7 pin mode 0.15-0.30V
  assign sense_limit_code       = {st_ff.loop_ctrl[LP_SENSE_TO_PIN],
                                   st_ff.loop_ctrl[LP_LIMIT_HI],
                                   st_ff.loop_ctrl[LP_LIMIT_LO]};
  assign pump_force_low         = st_ff.loop_ctrl[LP_PUMP_FORCE_LO];
  assign pump_force_high        = st_ff.loop_ctrl[LP_PUMP_FORCE_HI];
  // drivers float while the shutdown flag stands, regardless of the control bits
  assign spindle_drive_tristate = st_ff.mon[0];
  assign park_volt_code         = {st_ff.sys_ctrl[SC_PARK_VOLT_A],
                                   st_ff.sys_ctrl[SC_PARK_VOLT_B]};
  assign ref_connect            = st_ff.sys_ctrl[SC_REF_CONNECT];
  assign park_time_code         = {st_ff.sys_ctrl[SC_PARK_TIME_A],
                                   st_ff.sys_ctrl[SC_PARK_TIME_B]};
  assign startup_time_x2        = st_ff.sys_ctrl[SC_STARTUP_X2];
  assign voice_coil_enable      = st_ff.sys_ctrl[SC_VCM_ENABLE];
  assign head_park_command      = st_ff.sys_ctrl[SC_HEAD_PARK];

endmodule // spindle_vcm_status_ctrl_regs

// ===== dv/spindle_regs_checker.sv
// checker: timing relations on the spindle/voice-coil register bank pins
// assumes it is bound onto spindle_vcm_status_ctrl_regs, one mclk domain
`timescale 1ns/10ps
module spindle_regs_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       arst_n,
  // serial port pins
  input wire logic       ser_sel_n,
  input wire logic       ser_dout_oe,
  // monitored levels and register outputs
  input wire logic       overtemp_shutdown_in,
  input wire logic [7:0] fine_count_low,
  input wire logic       sense_to_pin_sel,
  input wire logic [2:0] sense_limit_code,
  input wire logic       pump_force_high,
  input wire logic       spindle_drive_tristate,
  input wire logic       voice_coil_enable,
  input wire logic       head_park_command
);
  typedef struct packed {
    logic [3:0] idle;
    logic       seen;
  } chk_state_t;
  chk_state_t st_ff;
  chk_state_t nxt_st;
  // idle counter saturates so long gaps never wrap back to zero
  always_comb begin
    nxt_st = st_ff;
    nxt_st.seen = st_ff.seen | ~ser_sel_n;
    nxt_st.idle = ser_sel_n ? ((st_ff.idle == 4'hF) ? 4'hF : st_ff.idle + 4'h1) : 4'h0;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // eight cycles cover the reset synchroniser plus the three-flop filter
  sequence s_hot;
    overtemp_shutdown_in [*8];
  endsequence
  sequence s_cool;
    !overtemp_shutdown_in [*8];
  endsequence
  a_hot_tristate: assert property (s_hot |-> spindle_drive_tristate)
    else $error("drivers not tristated during shutdown");
  a_cool_release: assert property (s_cool |-> !spindle_drive_tristate)
    else $error("drivers still tristated after cooling");
  a_reset_clear: assert property (!st_ff.seen |-> fine_count_low == 8'h00 && sense_limit_code == 3'h0
    && !voice_coil_enable && !head_park_command) else $error("output set before any frame");
  a_fine_idle: assert property (st_ff.idle >= 4'hC |-> $stable(fine_count_low))
    else $error("fine count moved with port idle");
  a_loop_idle: assert property (st_ff.idle >= 4'hC |-> $stable({pump_force_high, sense_limit_code}))
    else $error("loop control moved with port idle");
  a_sys_idle: assert property (st_ff.idle >= 4'hC |-> $stable({voice_coil_enable, head_park_command}))
    else $error("system control moved with port idle");
  a_pin_tie: assert property (sense_limit_code[2] == sense_to_pin_sel)
    else $error("limit code disagrees with sense routing");
  a_oe_idle: assert property (st_ff.idle >= 4'h8 |-> !ser_dout_oe)
    else $error("read driver on outside a frame");
  a_oe_frame: assert property ($rose(ser_dout_oe) |-> !ser_sel_n)
    else $error("read driver started with frame deselected");
endmodule // spindle_regs_checker

bind spindle_vcm_status_ctrl_regs spindle_regs_checker chk_u (.mclk(mclk), .arst_n(arst_n),
  .ser_sel_n(ser_sel_n), .ser_dout_oe(ser_dout_oe), .overtemp_shutdown_in(overtemp_shutdown_in),
  .fine_count_low(fine_count_low), .sense_to_pin_sel(sense_to_pin_sel), .sense_limit_code(sense_limit_code),
  .pump_force_high(pump_force_high), .spindle_drive_tristate(spindle_drive_tristate),
  .voice_coil_enable(voice_coil_enable), .head_park_command(head_park_command));

// ===== dv/host_serial_model.sv
// host model: drives LSB-first serial frames and collects read data
// assumes it shares mclk with the device; serial clock idles low between frames
`timescale 1ns/10ps
module host_serial_model
  import spindle_regs_pkg::*;
#(
  parameter int HALF = 6
)(
  // clock
  input wire logic mclk,
  // serial pins
  output logic     ser_sel_n,
  output logic     ser_clk,
  output logic     ser_din,
  input wire logic ser_dout
);
  initial begin
    ser_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end
  // pins change just after an edge, never on it
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one frame; fewer than 16 bits cuts it short
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] data,
                      input int nbits, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {data, addr, rd};
    if (!rd && addr == ADDR_LOOP_CTRL) frame[10] = 1'b0;
    rdata = 8'h00;
    wait_clk(1);
    ser_sel_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      ser_din = frame[i];
      wait_clk(HALF);
      if (i >= 8) rdata[i-8] = ser_dout;
      ser_clk = 1'b1;
      wait_clk(HALF);
      ser_clk = 1'b0;
    end
    wait_clk(HALF);
    ser_sel_n = 1'b1;
    ser_din = ~ser_din; // released line shows no stale bit
    wait_clk(6);
  endtask
endmodule // host_serial_model

// ===== dv/tb_spindle_vcm_status_ctrl_regs.sv
// testbench: register writes, refusals, status reads and resets through the serial port
// assumes host_serial_model as far side and a short speed-lock limit
`timescale 1ns/10ps
module tb_spindle_vcm_status_ctrl_regs
  import spindle_regs_pkg::*;
;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_t;
  localparam row_t ROWS [13] = '{'{ADDR_FINE_LOW, 8'h01, 8'h01}, '{ADDR_FINE_LOW, 8'hA5, 8'hA5},
    '{ADDR_FINE_LOW, 8'h80, 8'h80}, '{ADDR_LOOP_CTRL, 8'h01, 8'h01}, '{ADDR_LOOP_CTRL, 8'h02, 8'h02},
    '{ADDR_LOOP_CTRL, 8'h40, 8'h40}, '{ADDR_LOOP_CTRL, 8'h80, 8'h80}, '{ADDR_LOOP_CTRL, 8'hFF, 8'hFB},
    '{ADDR_SYS_CTRL, 8'h04, 8'h04}, '{ADDR_SYS_CTRL, 8'h10, 8'h10}, '{ADDR_SYS_CTRL, 8'h20, 8'h20},
    '{ADDR_SYS_CTRL, 8'h80, 8'h80}, '{ADDR_SYS_CTRL, 8'hFF, 8'hFF}};
  // {shutdown, warning, decel, zc_fast, mask, align, go, zc_evt, tick_en} beside expected status
  localparam logic [16:0] STAT [6] = '{{9'h001, 8'hF7}, {9'h1FF, 8'h2C}, {9'h041, 8'hFF},
    {9'h021, 8'hFF}, {9'h000, 8'hD3}, {9'h002, 8'hD7}};
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic [8:0] mon_in = '0;
  logic       tick = 1'b0;
  logic       ser_sel_n, ser_clk, ser_din, ser_dout, ser_dout_oe;
  logic [7:0] fine_count_low;
  logic       spindle_chop_slew_sel, pump_current_sel, sense_to_pin_sel, pump_force_low, pump_force_high;
  logic [2:0] sense_limit_code;
  logic       spindle_drive_tristate, ref_connect, startup_time_x2, voice_coil_enable, head_park_command;
  logic [1:0] park_volt_code, park_time_code;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc_count = 0;
  always #50 mclk = ~mclk;
  // spindle period ticks every 20 cycles, well inside the 100-cycle lock limit
  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    if (mon_in[0] && cyc_count % 10 == 0) tick <= #1 ~tick;
    if (cyc_count == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  host_serial_model host_u (.mclk(mclk), .ser_sel_n(ser_sel_n), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_dout(ser_dout));
  spindle_vcm_status_ctrl_regs #(.SPEED_LOCK_LIMIT(100)) dut_u (.mclk(mclk), .arst_n(arst_n),
    .ser_sel_n(ser_sel_n), .ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .overtemp_shutdown_in(mon_in[8]), .overtemp_warning_in(mon_in[7]), .fast_decel_in(mon_in[6]),
    .zero_cross_fast_in(mon_in[5]), .bemf_mask_in(mon_in[4]), .start_align_in(mon_in[3]),
    .start_go_in(mon_in[2]), .zero_cross_evt_in(mon_in[1]), .period_tick_in(tick),
    .fine_count_low(fine_count_low), .spindle_chop_slew_sel(spindle_chop_slew_sel),
    .pump_current_sel(pump_current_sel), .sense_to_pin_sel(sense_to_pin_sel), .sense_limit_code(sense_limit_code),
    .pump_force_low(pump_force_low), .pump_force_high(pump_force_high),
    .spindle_drive_tristate(spindle_drive_tristate), .park_volt_code(park_volt_code), .ref_connect(ref_connect),
    .park_time_code(park_time_code), .startup_time_x2(startup_time_x2), .voice_coil_enable(voice_coil_enable),
    .head_park_command(head_park_command));
  ////////////////////////////////////////////////////////////////////////////
  // register as seen at the output pins, bit for bit
  function automatic logic [7:0] reg_view(input logic [6:0] a);
    case (a)
      ADDR_FINE_LOW: return fine_count_low;
      ADDR_LOOP_CTRL: return {pump_force_high, pump_force_low, sense_limit_code[0], sense_limit_code[1],
                              sense_to_pin_sel, 1'b0, pump_current_sel, spindle_chop_slew_sel};
      default: return {head_park_command, park_time_code[0], voice_coil_enable, startup_time_x2,
                       park_time_code[1], ref_connect, park_volt_code[0], park_volt_code[1]};
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(1'b0, a, d, 16, q);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'b1;
    host_u.wait_clk(6);
    check("fine reset", reg_view(ADDR_FINE_LOW), RST_FINE_LOW);
    check("loop reset", reg_view(ADDR_LOOP_CTRL), RST_LOOP_CTRL);
    check("sys reset", reg_view(ADDR_SYS_CTRL), RST_SYS_CTRL);
    foreach (ROWS[i]) begin
      wr(ROWS[i].addr, ROWS[i].data);
      check("row", reg_view(ROWS[i].addr), ROWS[i].exp);
    end
    // every limit code, routed and normal
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_LOOP_CTRL, {2'b00, c[0], c[1], c[2], 3'b000});
      check("limit", {5'h00, sense_limit_code}, 8'(c));
    end
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SYS_CTRL, {1'b0, k[0], 2'b00, k[1], 1'b0, k[0], k[1]});
      check("park", {4'h0, park_volt_code, park_time_code}, {4'h0, 2'(k), 2'(k)});
    end
    // read-only, unmapped and cut-short frames leave the register alone
    wr(ADDR_FINE_LOW, 8'h5A);
    wr(ADDR_STATUS, 8'hFF);
    wr(7'h5E, 8'hFF);
    host_u.xfer(1'b0, ADDR_FINE_LOW, 8'h00, 12, q);
    check("refused", fine_count_low, 8'h5A);
    host_u.xfer(1'b1, ADDR_FINE_LOW, 8'h00, 16, q);
    check("wo read", q, 8'h00);
    // status flags; 150 idle cycles let filters and the lock timer settle
    foreach (STAT[i]) begin
      mon_in = STAT[i][16:8];
      host_u.wait_clk(150);
      host_u.xfer(1'b1, ADDR_STATUS, 8'h00, 16, q);
      check("status", q, STAT[i][7:0]);
      check("tristate", {7'h00, spindle_drive_tristate}, {7'h00, STAT[i][16]});
    end
    // reset in mid-run clears the written controls
    wr(ADDR_SYS_CTRL, 8'hA4);
    arst_n = 1'b0;
    host_u.wait_clk(2);
    arst_n = 1'b1;
    host_u.wait_clk(6);
    check("sys rereset", reg_view(ADDR_SYS_CTRL), RST_SYS_CTRL);
    give_verdict();
  end
endmodule // tb_spindle_vcm_status_ctrl_regs
